//--- inc/osc_pkg.sv
/*
  Shared constants for the oscillator control block: register offsets,
  field positions, reset values and the switch state type.
  Assumes a 32-bit APB bus with word-aligned registers.
*/
package osc_pkg;
  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CTRL_CLR = 8'h04;
  localparam logic [7:0] ADDR_CTRL_SET = 8'h08;
  localparam logic [7:0] ADDR_CTRL_INV = 8'h0C;
  localparam logic [7:0] ADDR_TUNE = 8'h10;
  localparam logic [7:0] ADDR_TUNE_CLR = 8'h14;
  localparam logic [7:0] ADDR_TUNE_SET = 8'h18;
  localparam logic [7:0] ADDR_TUNE_INV = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h20;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h24;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h28;
  localparam logic [7:0] ADDR_IRQ_PRIO = 8'h2C;
  // ****************************************
  // control register fields
  // ****************************************
  localparam int PLLDIV_LSB = 27;
  localparam int RCDIV_LSB = 24;
  localparam int SECONDARY_OSCILLATOR_RDY_BIT = 22;
  localparam int CUR_SEL_LSB = 12;
  localparam int NEXT_SEL_LSB = 8;
  localparam int FREEZE_BIT = 7;
  localparam int USB_LOCK_BIT = 6;
  localparam int PLL_LOCK_BIT = 5;
  localparam int SLEEP_BIT = 4;
  localparam int FAIL_BIT = 3;
  localparam int USB_RC_BIT = 2;
  localparam int SECONDARY_OSCILLATOR_EN_BIT = 1;
  localparam int SWITCH_BIT = 0;
  // software-writable bits through direct and alias writes
  localparam logic [31:0] CTRL_WMASK = 32'h3F00_0797;
  localparam logic [31:0] TUNE_WMASK = 32'h0000_003F;
  localparam logic [2:0] RCDIV_RESET = 3'h1;
  localparam int CFG2_PLLDIV_LSB = 16;
  // ****************************************
  // interrupt register fields
  // ****************************************
  localparam int IRQ_FAIL_BIT = 14;
  localparam int PRIO_LSB = 10;
  localparam int SUBPRIO_LSB = 8;
  localparam logic [31:0] PRIO_WMASK = 32'h0000_1F00;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ = 100;
  localparam int SWITCH_NS = 100;
  localparam int SWITCH_CYC = (SWITCH_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] SWITCH_CYC_W = 8'(SWITCH_CYC);
  typedef enum logic [1:0] {SW_IDLE = 2'b00, SW_WAIT = 2'b01, SW_DONE = 2'b11} sw_state_t;
endpackage

//--- logic/pow2_divider.sv
/*
  Power-of-two clock-enable divider: a pulse every 1,2,4..64,256 cycles.
  Assumes code changes come from a register on the same clock.
*/
module pow2_divider (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // divide code
  input wire logic [2:0] code,
  // divided tick
  output logic tick
);
  typedef struct packed {
    logic [7:0] count;
    logic tick;
  } div_t;
  div_t cur, next_cur;
  logic [7:0] limit;

  always_comb begin
    limit = (code == 3'h7) ? 8'hFF : 8'((9'h001 << code) - 9'h001);
    next_cur = cur;
    if (cur.count >= limit) begin
      next_cur.count = 8'h00;
      next_cur.tick = 1'b1;
    end else begin
      next_cur.count = cur.count + 8'h01;
      next_cur.tick = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign tick = cur.tick;
endmodule

//--- logic/sync2.sv
/*
  Two-flop level synchroniser for pins from other domains.
  Assumes the input is a slow level.
*/
module sync2 (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // level in and out
  input wire logic din,
  output logic dout
);
  typedef struct packed {
    logic meta;
    logic sync;
  } sync_t;
  sync_t cur, next_cur;

  always_comb begin
    next_cur.meta = din;
    next_cur.sync = cur.meta;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign dout = cur.sync;
endmodule

//--- logic/osc_control.sv
/*
  Oscillator control registers behind an APB slave: control and tuning
  registers with clear/set/invert aliases, clock-fail interrupt, divider ticks.
  Assumes oscillator status pins are asynchronous and the muxes live outside.
*/
module osc_control (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // configuration words
  input wire logic [31:0] config_word_2,
  input wire logic monitor_enable_config,
  input wire logic [2:0] boot_source_sel,
  // oscillator status pins
  input wire logic secondary_osc_stable,
  input wire logic pll_locked,
  input wire logic usb_pll_settled,
  input wire logic fail_safe_monitor,
  // clock control outputs
  output logic pll_div_tick,
  output logic rc_div_tick,
  output logic [2:0] current_source_sel,
  output logic [5:0] fast_rc_trim,
  output logic sleep_on_wait,
  output logic usb_rc_source_enable,
  output logic secondary_osc_enable,
  // interrupt
  output logic clock_fail_irq
);
  typedef struct packed {
    logic [2:0] pll_output_divider;
    logic [2:0] rc_divider;
    logic [2:0] current_source_sel;
    logic [2:0] next_source_sel;
    logic selection_freeze;
    logic sleep_on_wait;
    logic clock_fail_flag;
    logic usb_rc_source_enable;
    logic secondary_osc_enable;
    logic switch_request;
    logic [5:0] fast_rc_trim;
    logic clock_fail_irq_flag;
    logic clock_fail_irq_enable;
    logic [2:0] clock_fail_irq_priority;
    logic [1:0] clock_fail_irq_subpriority;
    osc_pkg::sw_state_t sw_state;
    logic [7:0] sw_count;
    logic boot_load;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
  } state_t;
  state_t cur, next_cur;
  logic secondary_oscillator_stable_s, pll_lock_s, usb_lock_s, fail_s;
  logic [31:0] ctrl_view, ctrl_new, tune_new, wdata;
  logic wr_access, setup_phase, frozen, pll_tick, rc_tick;

  // ****************************************
  // pin synchronisers
  // ****************************************
  sync2 u_sync_secondary_oscillator (.clock(clock), .sys_rst(sys_rst), .din(secondary_osc_stable),
    .dout(secondary_oscillator_stable_s));
  sync2 u_sync_pll (.clock(clock), .sys_rst(sys_rst), .din(pll_locked), .dout(pll_lock_s));
  sync2 u_sync_usb (.clock(clock), .sys_rst(sys_rst), .din(usb_pll_settled),
    .dout(usb_lock_s));
  sync2 u_sync_fail (.clock(clock), .sys_rst(sys_rst), .din(fail_safe_monitor),
    .dout(fail_s));

  // ****************************************
  // dividers
  // ****************************************
  pow2_divider u_pll_div (.clock(clock), .sys_rst(sys_rst),
    .code(cur.pll_output_divider), .tick(pll_tick));
  pow2_divider u_rc_div (.clock(clock), .sys_rst(sys_rst),
    .code(cur.rc_divider), .tick(rc_tick));

  always_comb begin
    ctrl_view = '0;
    ctrl_view[osc_pkg::PLLDIV_LSB +: 3] = cur.pll_output_divider;
    ctrl_view[osc_pkg::RCDIV_LSB +: 3] = cur.rc_divider;
    // ready only while enabled and stable
    ctrl_view[osc_pkg::SECONDARY_OSCILLATOR_RDY_BIT] = secondary_oscillator_stable_s & cur.secondary_osc_enable;
    ctrl_view[osc_pkg::CUR_SEL_LSB +: 3] = cur.current_source_sel;
    ctrl_view[osc_pkg::NEXT_SEL_LSB +: 3] = cur.next_source_sel;
    ctrl_view[osc_pkg::FREEZE_BIT] = cur.selection_freeze;
    ctrl_view[osc_pkg::USB_LOCK_BIT] = usb_lock_s;
    ctrl_view[osc_pkg::PLL_LOCK_BIT] = pll_lock_s;
    ctrl_view[osc_pkg::SLEEP_BIT] = cur.sleep_on_wait;
    ctrl_view[osc_pkg::FAIL_BIT] = cur.clock_fail_flag;
    ctrl_view[osc_pkg::USB_RC_BIT] = cur.usb_rc_source_enable;
    ctrl_view[osc_pkg::SECONDARY_OSCILLATOR_EN_BIT] = cur.secondary_osc_enable;
    ctrl_view[osc_pkg::SWITCH_BIT] = cur.switch_request;
  end

  // ****************************************
  // register and switch logic
  // ****************************************
  always_comb begin
    next_cur = cur;
    wdata = pwdata;
    wr_access = psel & penable & pwrite;
    setup_phase = psel & ~penable;
    frozen = cur.selection_freeze & monitor_enable_config;
    ctrl_new = ctrl_view;
    tune_new = {26'h0, cur.fast_rc_trim};
    next_cur.pready = setup_phase;
    next_cur.pslverr = 1'b0;
    next_cur.prdata = '0;
    next_cur.boot_load = 1'b0;
    if (cur.boot_load) begin
      next_cur.pll_output_divider = config_word_2[osc_pkg::CFG2_PLLDIV_LSB +: 3];
      next_cur.current_source_sel = boot_source_sel;
      next_cur.next_source_sel = boot_source_sel;
    end
    if (wr_access & cur.pready) begin
      case (paddr)
        osc_pkg::ADDR_CTRL: ctrl_new = wdata;
        osc_pkg::ADDR_CTRL_CLR: ctrl_new = ctrl_view & ~wdata;
        osc_pkg::ADDR_CTRL_SET: ctrl_new = ctrl_view | wdata;
        osc_pkg::ADDR_CTRL_INV: ctrl_new = ctrl_view ^ wdata;
        osc_pkg::ADDR_TUNE: tune_new = wdata;
        osc_pkg::ADDR_TUNE_CLR: tune_new = {26'h0, cur.fast_rc_trim} & ~wdata;
        osc_pkg::ADDR_TUNE_SET: tune_new = {26'h0, cur.fast_rc_trim} | wdata;
        osc_pkg::ADDR_TUNE_INV: tune_new = {26'h0, cur.fast_rc_trim} ^ wdata;
        osc_pkg::ADDR_IRQ_CLEAR: begin
          if (wdata[osc_pkg::IRQ_FAIL_BIT]) begin
            next_cur.clock_fail_irq_flag = 1'b0;
          end
        end
        osc_pkg::ADDR_IRQ_ENABLE: begin
          next_cur.clock_fail_irq_enable = wdata[osc_pkg::IRQ_FAIL_BIT];
        end
        osc_pkg::ADDR_IRQ_PRIO: begin
          next_cur.clock_fail_irq_priority = wdata[osc_pkg::PRIO_LSB +: 3];
          next_cur.clock_fail_irq_subpriority = wdata[osc_pkg::SUBPRIO_LSB +: 2];
        end
        osc_pkg::ADDR_IRQ_STATUS: next_cur.pslverr = 1'b0;
        // error answer already given in the setup cycle
        default: ctrl_new = ctrl_view;
      endcase
      // only writable bits take the new value
      ctrl_new = (ctrl_new & osc_pkg::CTRL_WMASK) | (ctrl_view & ~osc_pkg::CTRL_WMASK);
      if (!frozen) begin
        next_cur.pll_output_divider = ctrl_new[osc_pkg::PLLDIV_LSB +: 3];
        next_cur.next_source_sel = ctrl_new[osc_pkg::NEXT_SEL_LSB +: 3];
      end
      next_cur.rc_divider = ctrl_new[osc_pkg::RCDIV_LSB +: 3];
      // freeze is sticky until reset
      next_cur.selection_freeze = ctrl_new[osc_pkg::FREEZE_BIT] | cur.selection_freeze;
      next_cur.sleep_on_wait = ctrl_new[osc_pkg::SLEEP_BIT];
      next_cur.usb_rc_source_enable = ctrl_new[osc_pkg::USB_RC_BIT];
      next_cur.secondary_osc_enable = ctrl_new[osc_pkg::SECONDARY_OSCILLATOR_EN_BIT];
      if (!frozen && ctrl_new[osc_pkg::SWITCH_BIT] && cur.sw_state == osc_pkg::SW_IDLE) begin
        next_cur.switch_request = 1'b1;
      end
      next_cur.fast_rc_trim = tune_new[5:0] & osc_pkg::TUNE_WMASK[5:0];
    end
    // answer built in the setup cycle so it stands with pready
    if (setup_phase) begin
      case (paddr)
        osc_pkg::ADDR_CTRL: next_cur.prdata = ctrl_view;
        osc_pkg::ADDR_TUNE: next_cur.prdata = {26'h0, cur.fast_rc_trim};
        osc_pkg::ADDR_IRQ_STATUS: next_cur.prdata[osc_pkg::IRQ_FAIL_BIT] = cur.clock_fail_irq_flag;
        osc_pkg::ADDR_IRQ_ENABLE:
          next_cur.prdata[osc_pkg::IRQ_FAIL_BIT] = cur.clock_fail_irq_enable;
        osc_pkg::ADDR_IRQ_PRIO: next_cur.prdata = {19'h0, cur.clock_fail_irq_priority,
          cur.clock_fail_irq_subpriority, 8'h00};
        osc_pkg::ADDR_CTRL_CLR, osc_pkg::ADDR_CTRL_SET, osc_pkg::ADDR_CTRL_INV,
        osc_pkg::ADDR_TUNE_CLR, osc_pkg::ADDR_TUNE_SET, osc_pkg::ADDR_TUNE_INV,
        osc_pkg::ADDR_IRQ_CLEAR: next_cur.prdata = '0;
        default: next_cur.pslverr = 1'b1;
      endcase
      // a write answers with zero data
      if (pwrite) begin
        next_cur.prdata = '0;
      end
    end
    // failure events win over software clear
    if (fail_s) begin
      next_cur.clock_fail_flag = 1'b1;
      next_cur.clock_fail_irq_flag = 1'b1;
    end
    case (cur.sw_state)
      osc_pkg::SW_IDLE: begin
        next_cur.sw_count = '0;
        if (cur.switch_request) begin
          next_cur.sw_state = osc_pkg::SW_WAIT;
        end
      end
      osc_pkg::SW_WAIT: begin
        next_cur.sw_count = cur.sw_count + 8'h01;
        if (cur.sw_count >= osc_pkg::SWITCH_CYC_W - 8'h01) begin
          next_cur.sw_state = osc_pkg::SW_DONE;
        end
      end
      osc_pkg::SW_DONE: begin
        next_cur.current_source_sel = cur.next_source_sel;
        next_cur.switch_request = 1'b0;
        next_cur.sw_state = osc_pkg::SW_IDLE;
      end
      default: next_cur.sw_state = osc_pkg::SW_IDLE;
    endcase
    next_cur.irq = next_cur.clock_fail_irq_flag & next_cur.clock_fail_irq_enable;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cur <= '0;
      cur.rc_divider <= osc_pkg::RCDIV_RESET;
      cur.boot_load <= 1'b1;
      cur.sw_state <= osc_pkg::SW_IDLE;
    end else begin
      cur <= next_cur;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign prdata = cur.prdata;
  assign pready = cur.pready;
  assign pslverr = cur.pslverr;
  assign pll_div_tick = pll_tick;
  assign rc_div_tick = rc_tick;
  assign current_source_sel = cur.current_source_sel;
  assign fast_rc_trim = cur.fast_rc_trim;
  assign sleep_on_wait = cur.sleep_on_wait;
  assign usb_rc_source_enable = cur.usb_rc_source_enable;
  assign secondary_osc_enable = cur.secondary_osc_enable;
  assign clock_fail_irq = cur.irq;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_fail_sets_flag: assert property (fail_s |=> cur.clock_fail_flag)
    else $error("fail flag not set");
  a_fail_sets_irqflag: assert property (fail_s |=> cur.clock_fail_irq_flag)
    else $error("fail irq flag not set");
  a_irq_level: assert property (clock_fail_irq == (cur.clock_fail_irq_flag &
    cur.clock_fail_irq_enable))
    else $error("irq output mismatch");
  a_switch_clears: assert property ($rose(cur.switch_request) |-> ##[1:20]
    !cur.switch_request)
    else $error("switch not completed");
  a_freeze_holds: assert property (frozen && !cur.boot_load |=>
    $stable(cur.next_source_sel))
    else $error("frozen selection changed");
  a_ready_gated: assert property (!cur.secondary_osc_enable |->
    !ctrl_view[osc_pkg::SECONDARY_OSCILLATOR_RDY_BIT])
    else $error("ready while disabled");
  a_reserved_zero: assert property (ctrl_view[31:30] == 2'h0)
    else $error("reserved bits nonzero");
  a_alias_zero: assert property (wr_access && cur.pready &&
    paddr == osc_pkg::ADDR_TUNE_SET && pwdata == 32'h0 |=> $stable(cur.fast_rc_trim))
    else $error("zero alias changed trim");
  a_tune_clear: assert property (wr_access && cur.pready &&
    paddr == osc_pkg::ADDR_TUNE_CLR |=> (cur.fast_rc_trim & $past(pwdata[5:0])) == 6'h00)
    else $error("clear alias failed");
  a_ctrl_set: assert property (wr_access && cur.pready && !frozen &&
    paddr == osc_pkg::ADDR_CTRL_SET && pwdata[osc_pkg::SLEEP_BIT] |=> cur.sleep_on_wait)
    else $error("set alias failed");

  // ****************************************
  // register write, boot, flag and switch checks
  // ****************************************
  a_boot_load: assert property (cur.boot_load |=>
    cur.pll_output_divider == $past(config_word_2[osc_pkg::CFG2_PLLDIV_LSB +: 3]) &&
    cur.current_source_sel == $past(boot_source_sel))
    else $error("boot fields not loaded");
  a_pll_div_write: assert property (wr_access && cur.pready && !frozen &&
    paddr == osc_pkg::ADDR_CTRL |=>
    cur.pll_output_divider == $past(pwdata[osc_pkg::PLLDIV_LSB +: 3]))
    else $error("pll divider not written");
  a_rc_div_write: assert property (wr_access && cur.pready &&
    paddr == osc_pkg::ADDR_CTRL |=> cur.rc_divider == $past(pwdata[osc_pkg::RCDIV_LSB +: 3]))
    else $error("rc divider not written");
  a_ctrl_invert: assert property (wr_access && cur.pready &&
    paddr == osc_pkg::ADDR_CTRL_INV |=>
    cur.sleep_on_wait == ($past(cur.sleep_on_wait) ^ $past(pwdata[osc_pkg::SLEEP_BIT])))
    else $error("invert alias failed");
  a_tune_set: assert property (wr_access && cur.pready &&
    paddr == osc_pkg::ADDR_TUNE_SET |=>
    (cur.fast_rc_trim & $past(pwdata[5:0])) == $past(pwdata[5:0]))
    else $error("set alias failed on trim");
  a_fail_readonly: assert property (wr_access && cur.pready && cur.clock_fail_flag &&
    paddr == osc_pkg::ADDR_CTRL_CLR |=> cur.clock_fail_flag)
    else $error("clear alias hit read-only bit");
  a_fail_quiet: assert property (!cur.clock_fail_flag && !fail_s |=>
    !cur.clock_fail_flag)
    else $error("fail flag without failure");
  a_freeze_div: assert property (frozen && !cur.boot_load |=>
    $stable(cur.pll_output_divider))
    else $error("frozen divider changed");
  a_switch_done: assert property (cur.sw_state == osc_pkg::SW_DONE |=>
    cur.current_source_sel == $past(cur.next_source_sel) && !cur.switch_request)
    else $error("switch did not complete");
  a_irq_clear: assert property (wr_access && cur.pready && !fail_s &&
    paddr == osc_pkg::ADDR_IRQ_CLEAR && pwdata[osc_pkg::IRQ_FAIL_BIT] |=>
    !cur.clock_fail_irq_flag)
    else $error("irq flag not cleared");
  a_irq_enable: assert property (wr_access && cur.pready &&
    paddr == osc_pkg::ADDR_IRQ_ENABLE |=>
    cur.clock_fail_irq_enable == $past(pwdata[osc_pkg::IRQ_FAIL_BIT]))
    else $error("irq enable not written");
  a_irq_prio: assert property (wr_access && cur.pready &&
    paddr == osc_pkg::ADDR_IRQ_PRIO |=>
    cur.clock_fail_irq_priority == $past(pwdata[osc_pkg::PRIO_LSB +: 3]) &&
    cur.clock_fail_irq_subpriority == $past(pwdata[osc_pkg::SUBPRIO_LSB +: 2]))
    else $error("priority not written");

  c_switch: cover property (cur.sw_state == osc_pkg::SW_DONE);
  c_fail_irq: cover property ($rose(clock_fail_irq));
  c_alias_inv: cover property (wr_access && paddr == osc_pkg::ADDR_CTRL_INV);
  c_frozen_write: cover property (frozen && wr_access && paddr == osc_pkg::ADDR_CTRL);
  c_bus_error: cover property (pready && pslverr);
endmodule

//--- testbench/tb.sv
/*
  Self-checking bench for osc_control: an APB driver notes each expected
  answer in a queue and a bus monitor checks every answer against it.
  Assumes osc_pkg and a one-cycle registered APB answer.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // signals
  // ****************************************
  localparam logic [31:0] CM = 32'h3F40_77FF;
  localparam logic [31:0] WM = 32'h3F00_0716;
  typedef struct {logic [31:0] d; logic [31:0] m; logic e;} note_t;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] config_word_2 = 32'h0005_0000;
  logic monitor_enable_config = 1'b1;
  logic [2:0] boot_sel = 3'h2;
  logic secondary_oscillator_stable = 1'b0;
  logic pll_locked = 1'b0;
  logic usb_settled = 1'b0;
  logic fail_pin = 1'b0;
  logic pll_div_tick;
  logic rc_div_tick;
  logic [2:0] current_source_sel;
  logic [5:0] fast_rc_trim;
  logic sleep_on_wait;
  logic usb_rc_source_enable;
  logic secondary_osc_enable;
  logic clock_fail_irq;
  int n_fail = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [31:0] lfsr = 32'h6B4E;
  logic [31:0] ec;
  logic [31:0] et;
  note_t q[$];

  always #5 clock = ~clock;

  osc_control DUT (
    .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .config_word_2(config_word_2), .monitor_enable_config(monitor_enable_config),
    .boot_source_sel(boot_sel), .secondary_osc_stable(secondary_oscillator_stable), .pll_locked(pll_locked),
    .usb_pll_settled(usb_settled), .fail_safe_monitor(fail_pin), .pll_div_tick(pll_div_tick),
    .rc_div_tick(rc_div_tick), .current_source_sel(current_source_sel),
    .fast_rc_trim(fast_rc_trim), .sleep_on_wait(sleep_on_wait),
    .usb_rc_source_enable(usb_rc_source_enable), .secondary_osc_enable(secondary_osc_enable),
    .clock_fail_irq(clock_fail_irq)
  );

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  task automatic chk(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic fin(input string s);
    $display("test %s finished", s);
  endtask

  // one transfer; a write notes an empty mask so only pslverr is compared
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] m, input logic e);
    int n;
    q.push_back('{d & m, m, e});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do @(posedge clock); while (pready !== 1'b1 && n++ < 20);
    if (n >= 20) chk(1'b0, "no answer");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 32'h0, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    xfer(1'b0, a, d, m, 1'b0);
  endtask

  task automatic do_reset();
    sys_rst <= 1'b1;
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clock);
    ec = {2'b00, config_word_2[18:16], 3'b001, 8'h00, 1'b0, boot_sel, 1'b0, boot_sel, 8'h00};
    et = 32'h0;
  endtask

  // gap between the second and third tick after a code change
  task automatic tick_gap(input logic pll, output int n);
    for (int k = 0; k < 3; k++) begin
      n = 0;
      do begin
        @(posedge clock);
        n++;
      end while ((pll ? pll_div_tick : rc_div_tick) !== 1'b1 && n < 600);
    end
  endtask

  // ****************************************
  // bus monitor
  // ****************************************
  always @(posedge clock) begin
    note_t nt;
    cycles++;
    if (psel && penable && pready === 1'b1) begin
      if (q.size() == 0) chk(1'b0, "answer without request");
      else begin
        nt = q.pop_front();
        chk(((prdata & nt.m) === nt.d) && (pslverr === nt.e), "bus answer");
      end
    end
    if (cycles == 60000) begin
      n_fail++;
      test_done();
    end
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    logic [31:0] v;
    int a;
    int n;
    do_reset();
    rd(osc_pkg::ADDR_CTRL, ec, CM);
    rd(osc_pkg::ADDR_TUNE, 32'h0, 32'h3F);
    rd(osc_pkg::ADDR_IRQ_STATUS, 32'h0, 32'h4000);
    rd(osc_pkg::ADDR_IRQ_ENABLE, 32'h0, 32'h4000);
    rd(osc_pkg::ADDR_IRQ_PRIO, 32'h0, osc_pkg::PRIO_WMASK);
    for (int i = 1; i < 8; i++) if (i != 4) rd(8'(i * 4), 32'h0, 32'hFFFF_FFFF);
    xfer(1'b0, 8'h30, 32'h0, 32'h0, 1'b1);
    xfer(1'b1, 8'h3C, rnd(), 32'h0, 1'b1);
    fin("reset");
    for (int i = 0; i < 12; i++) begin
      v = rnd();
      a = i % 4;
      wr(osc_pkg::ADDR_TUNE + 8'(4 * a), v);
      case (a)
        0: et = v & osc_pkg::TUNE_WMASK;
        1: et = et & ~v;
        2: et = et | (v & osc_pkg::TUNE_WMASK);
        default: et = et ^ (v & osc_pkg::TUNE_WMASK);
      endcase
      wr(osc_pkg::ADDR_TUNE_SET, 32'h0);
      wr(osc_pkg::ADDR_TUNE_CLR, 32'h0);
      rd(osc_pkg::ADDR_TUNE, et, 32'h3F);
      chk(fast_rc_trim === et[5:0], "trim output");
    end
    fin("tuning aliases");
    for (int i = 0; i < 9; i++) begin
      v = rnd() & ~32'hC000_0000;
      a = 1 + i % 3;
      wr(osc_pkg::ADDR_CTRL + 8'(4 * a), v & ~32'h0000_0081);
      case (a)
        1: ec = ec & ~(v & WM);
        2: ec = ec | (v & WM);
        default: ec = ec ^ (v & WM);
      endcase
      rd(osc_pkg::ADDR_CTRL, ec, CM);
      chk({sleep_on_wait, usb_rc_source_enable, secondary_osc_enable} === {ec[4], ec[2], ec[1]},
          "control outputs");
    end
    fin("control aliases");
    for (int c = 0; c < 8; c++) begin
      ec[29:24] = {3'(c), 3'(c)};
      wr(osc_pkg::ADDR_CTRL, ec);
      tick_gap(1'b1, n);
      chk(n === ((c == 7) ? 256 : (1 << c)), "pll divide");
      tick_gap(1'b0, n);
      chk(n === ((c == 7) ? 256 : (1 << c)), "rc divide");
    end
    fin("dividers");
    ec[10:8] = 3'h5;
    wr(osc_pkg::ADDR_CTRL, ec | 32'h1);
    n = 0;
    while (current_source_sel !== 3'h5 && n++ < 100) @(posedge clock);
    chk(current_source_sel === 3'h5, "source switch");
    repeat (2) @(posedge clock);
    ec[14:12] = 3'h5;
    rd(osc_pkg::ADDR_CTRL, ec, CM);
    fin("switch");
    secondary_oscillator_stable <= 1'b1;
    pll_locked <= 1'b1;
    usb_settled <= 1'b1;
    wr(osc_pkg::ADDR_CTRL_SET, 32'h2);
    repeat (6) @(posedge clock);
    ec = ec | 32'h0040_0062;
    rd(osc_pkg::ADDR_CTRL, ec, CM);
    wr(osc_pkg::ADDR_CTRL_CLR, 32'h2);
    repeat (6) @(posedge clock);
    ec = ec & ~32'h0040_0002;
    rd(osc_pkg::ADDR_CTRL, ec, CM);
    secondary_oscillator_stable <= 1'b0;
    pll_locked <= 1'b0;
    usb_settled <= 1'b0;
    ec[6:5] = 2'h0;
    fin("ready flag");
    v = rnd();
    wr(osc_pkg::ADDR_IRQ_PRIO, v);
    rd(osc_pkg::ADDR_IRQ_PRIO, v, osc_pkg::PRIO_WMASK);
    fail_pin <= 1'b1;
    repeat (6) @(posedge clock);
    ec[3] = 1'b1;
    rd(osc_pkg::ADDR_CTRL, ec, CM);
    rd(osc_pkg::ADDR_IRQ_STATUS, 32'h4000, 32'h4000);
    chk(clock_fail_irq === 1'b0, "irq masked");
    wr(osc_pkg::ADDR_IRQ_ENABLE, 32'h4000);
    repeat (2) @(posedge clock);
    chk(clock_fail_irq === 1'b1, "irq raised");
    fail_pin <= 1'b0;
    repeat (6) @(posedge clock);
    wr(osc_pkg::ADDR_IRQ_CLEAR, 32'h4000);
    repeat (2) @(posedge clock);
    chk(clock_fail_irq === 1'b0, "irq cleared");
    rd(osc_pkg::ADDR_IRQ_STATUS, 32'h0, 32'h4000);
    rd(osc_pkg::ADDR_CTRL, ec, CM);
    fin("clock fail");
    wr(osc_pkg::ADDR_CTRL_SET, 32'h80);
    ec[7] = 1'b1;
    wr(osc_pkg::ADDR_CTRL, ec ^ 32'h3800_0700);
    rd(osc_pkg::ADDR_CTRL, ec, CM);
    monitor_enable_config <= 1'b0;
    config_word_2 <= rnd();
    boot_sel <= 3'h6;
    do_reset();
    rd(osc_pkg::ADDR_CTRL, ec, CM);
    wr(osc_pkg::ADDR_CTRL_SET, 32'h80);
    ec = (ec | 32'h80) ^ 32'h3800_0700;
    wr(osc_pkg::ADDR_CTRL, ec);
    rd(osc_pkg::ADDR_CTRL, ec, CM);
    fin("freeze");
    chk(q.size() == 0, "answers missing");
    test_done();
  end
endmodule
